// >>> verilog/sync_serial_cfg.svh
// offsets, field positions, reset values and timing for the serial port
`ifndef SYNC_SERIAL_CFG_SVH
`define SYNC_SERIAL_CFG_SVH
`define OFS_BAUD_CONFIG 8'h00
`define OFS_RECEIVE_DATA 8'h04
`define OFS_RECEIVE_STATUS 8'h08
`define OFS_DIVISOR_LOW 8'h0C
`define OFS_DIVISOR_HIGH 8'h10
`define OFS_TRANSMIT_STATUS 8'h14
`define OFS_TRANSMIT_DATA 8'h18
`define OFS_IRQ_CONTROL 8'h1C
`define BIT_WIDE_BAUD 3
`define BIT_PORT_ENABLE 7
`define BIT_NINE_RX 6
`define BIT_SINGLE_RX 5
`define BIT_CONT_RX 4
`define BIT_FRAMING_ERR 2
`define BIT_OVERRUN 1
`define BIT_RX_NINTH 0
`define BIT_CLOCK_SOURCE 7
`define BIT_NINE_TX 6
`define BIT_TX_ENABLE 5
`define BIT_SYNC_MODE 4
`define BIT_HIGH_SPEED 2
`define BIT_SHIFT_EMPTY 1
`define BIT_TX_NINTH 0
`define BIT_RX_IRQ_EN 0
`define BIT_TX_IRQ_EN 1
`define BIT_PERIPH_IRQ_EN 2
`define BIT_GLOBAL_IRQ_EN 3
`define BIT_RX_FLAG 4
`define BIT_TX_FLAG 5
`define RESET_CONTROL 8'h00
`define RESET_DIVISOR 8'h00
`define LOW_SPEED_SCALE 2'h3
`define CHAR_BITS 4'h8
`define CHAR_BITS_NINE 4'h9
`endif

// >>> verilog/sync_serial_pkg.sv
// types shared by the synchronous serial port
package sync_serial_pkg;
  typedef enum logic [1:0] {
    mode_off = 2'b00,
    mode_idle = 2'b01,
    mode_rx = 2'b11,
    mode_tx = 2'b10
  } mode_t;
endpackage

// >>> verilog/pin_sync.sv
// two-flop synchroniser for pins entering the pclk domain
module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic [WIDTH-1:0] async_in, // raw pin levels
  output logic [WIDTH-1:0] sync_out // levels safe for pclk logic
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// >>> verilog/baud_tick.sv
// shift clock half-period tick from the 16-bit divisor
`include "sync_serial_cfg.svh"
module baud_tick (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic run, // count only while clocks are wanted
  input wire logic [15:0] divisor, // divisor pair, high:low
  input wire logic wide, // use all 16 divisor bits
  input wire logic high_speed, // drop the divide-by-four stage
  output logic tick // one-cycle pulse per half period
);
  logic [17:0] count;
  logic [15:0] eff;
  logic [17:0] terminal;

  assign eff = wide ? divisor : {8'h00, divisor[7:0]};
  // low speed gives (n+1)*4 cycles per half period
  assign terminal = high_speed ? {2'b00, eff} : {eff, `LOW_SPEED_SCALE};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else if (!run || count >= terminal)
    begin
      count <= '0;
      tick <= run;
    end
    else
    begin
      count <= count + 18'h00001;
      tick <= 1'b0;
    end
  end
endmodule

// >>> verilog/sync_serial_port.sv
// synchronous serial port: master/slave shift engine behind an apb slave
`include "sync_serial_cfg.svh"
module sync_serial_port (
  input wire logic pclk, // system clock, 100 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic cpu_sleep, // processor asleep, stops master clocks
  input wire logic ck_in, // shift clock pin level
  output logic ck_out, // shift clock driven as master
  output logic ck_oe, // shift clock drive enable
  input wire logic dt_in, // data pin level
  output logic dt_out, // data driven when transmitting
  output logic dt_oe, // data drive enable
  output logic wake_request, // wake the processor from sleep
  output logic irq_request // interrupt to the processor
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic wide_baud_counter;
  logic port_enable, nine_bit_receive;
  logic single_receive_enable, continuous_receive_enable;
  logic [7:0] div_lo, div_hi;
  logic clock_source_select, nine_bit_transmit, transmit_enable;
  logic sync_mode, high_speed_baud, transmit_ninth_bit;
  logic receive_irq_enable, transmit_irq_enable;
  logic peripheral_irq_enable, global_irq_enable;
  logic overrun_error_flag;
  sync_serial_pkg::mode_t mode;
  sync_serial_pkg::mode_t next_mode;

  logic access, wr, rd, pop, hit;
  logic [31:0] next_prdata;

  function automatic logic at(input logic [7:0] a, input logic [7:0] ofs);
    at = (a == ofs);
  endfunction

  assign access = psel && penable && pready;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;

  // one wait state so that read data and ready both leave flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      prdata <= next_prdata;
      pslverr <= psel && penable && !pready && !hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode and pins
  logic active, master, lead, trail, tick, run;
  logic ck_s, dt_s, ck_d;
  logic [3:0] rx_bits, tx_bits;

  assign active = port_enable && sync_mode;
  assign master = active && clock_source_select;
  assign rx_bits = nine_bit_receive ? `CHAR_BITS_NINE : `CHAR_BITS;
  assign tx_bits = nine_bit_transmit ? `CHAR_BITS_NINE : `CHAR_BITS;

  pin_sync #(.WIDTH(2)) u_pins (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({ck_in, dt_in}),
    .sync_out({ck_s, dt_s})
  );

  always_comb
  begin
    if (!active)
      next_mode = sync_serial_pkg::mode_off;
    else if (single_receive_enable || continuous_receive_enable)
      next_mode = sync_serial_pkg::mode_rx;
    else if (transmit_enable)
      next_mode = sync_serial_pkg::mode_tx;
    else
      next_mode = sync_serial_pkg::mode_idle;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode <= sync_serial_pkg::mode_off;
    else
      mode <= next_mode;
  end

  logic tsr_full;
  // master clocks stop in sleep and while the receiver is blocked by overrun
  assign run = master && !cpu_sleep && mode == next_mode
    && ((mode == sync_serial_pkg::mode_rx && !overrun_error_flag)
    || (mode == sync_serial_pkg::mode_tx && tsr_full));

  baud_tick u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .divisor({div_hi, div_lo}),
    .wide(wide_baud_counter),
    .high_speed(high_speed_baud),
    .tick(tick)
  );

  // idle-low clock: rising edge leads, falling edge trails
  always_comb
  begin
    unique case (master)
      1'b1:
      begin
        lead = tick && run && !ck_out;
        trail = tick && run && ck_out;
      end
      1'b0:
      begin
        lead = active && ck_s && !ck_d;
        trail = active && !ck_s && ck_d;
      end
    endcase
  end

  // slave edge lag is three pclk cycles; external clock must be much slower
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ck_d <= 1'b0;
      ck_out <= 1'b0;
      ck_oe <= 1'b0;
      dt_oe <= 1'b0;
    end
    else
    begin
      ck_d <= ck_s;
      ck_out <= run && (tick ? !ck_out : ck_out);
      ck_oe <= master;
      dt_oe <= active && next_mode == sync_serial_pkg::mode_tx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive shifter and two-entry queue
  logic [8:0] rx_shift, rx_next, rx_char;
  logic [3:0] rx_cnt;
  logic [8:0] queue [2];
  logic rd_ptr;
  logic [1:0] count;
  logic done, push, full, rx_live;

  assign rx_live = mode == sync_serial_pkg::mode_rx && next_mode == mode
    && !overrun_error_flag;
  assign rx_next = {dt_s, rx_shift[8:1]};
  assign rx_char = nine_bit_receive ? rx_next : {1'b0, rx_next[8:1]};
  assign done = rx_live && trail && rx_cnt == rx_bits - 4'h1;
  assign full = count == 2'h2;
  assign push = done && !full;
  assign pop = rd && at(paddr, `OFS_RECEIVE_DATA) && count != 2'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_shift <= 9'h000;
      rx_cnt <= 4'h0;
    end
    else if (!rx_live)
    begin
      rx_cnt <= 4'h0; // partial character dropped
    end
    else if (trail)
    begin
      rx_shift <= rx_next;
      rx_cnt <= done ? 4'h0 : rx_cnt + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      queue[0] <= 9'h000;
      queue[1] <= 9'h000;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else if (!port_enable)
    begin
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (push)
        queue[rd_ptr ^ count[0]] <= rx_char;
      if (pop)
        rd_ptr <= !rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  // set wins over any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overrun_error_flag <= 1'b0;
    else if (!port_enable)
      overrun_error_flag <= 1'b0;
    else if (done && full)
      overrun_error_flag <= 1'b1;
    else if (wr && at(paddr, `OFS_RECEIVE_STATUS) && !pwdata[`BIT_CONT_RX])
      overrun_error_flag <= 1'b0;
    else if (pop && !continuous_receive_enable)
      overrun_error_flag <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit buffer and shifter
  logic [8:0] tx_buf, transmit_shift_reg;
  logic buf_full;
  logic [3:0] tx_cnt;
  logic tx_live, tx_last, tx_write;

  assign tx_live = mode == sync_serial_pkg::mode_tx && next_mode == mode;
  assign tx_last = trail && tsr_full && tx_cnt == tx_bits - 4'h1;
  assign tx_write = wr && at(paddr, `OFS_TRANSMIT_DATA) && active;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_buf <= 9'h000;
      buf_full <= 1'b0;
      transmit_shift_reg <= 9'h000;
      tsr_full <= 1'b0;
      tx_cnt <= 4'h0;
      dt_out <= 1'b0;
    end
    else if (!active)
    begin
      buf_full <= 1'b0;
      tsr_full <= 1'b0;
      tx_cnt <= 4'h0;
      dt_out <= 1'b0;
    end
    else
    begin
      // a write into a full buffer is dropped
      if (tx_write && !buf_full)
      begin
        tx_buf <= {transmit_ninth_bit, pwdata[7:0]};
        buf_full <= 1'b1;
      end
      else if (buf_full && tx_live && (!tsr_full || tx_last))
      begin
        transmit_shift_reg <= tx_buf;
        tsr_full <= 1'b1;
        buf_full <= 1'b0;
        tx_cnt <= 4'h0;
      end
      if (!(buf_full && tx_live && (!tsr_full || tx_last)))
      begin
        if (tx_last)
        begin
          tsr_full <= 1'b0;
          tx_cnt <= 4'h0;
        end
        else if (trail && tsr_full && tx_live)
        begin
          transmit_shift_reg <= {1'b0, transmit_shift_reg[8:1]};
          tx_cnt <= tx_cnt + 4'h1;
        end
      end
      if (lead && tsr_full && tx_live)
        dt_out <= transmit_shift_reg[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {port_enable, nine_bit_receive} <= 2'b00;
      {single_receive_enable, continuous_receive_enable} <= 2'b00;
      wide_baud_counter <= 1'b0;
      div_lo <= `RESET_DIVISOR;
      div_hi <= `RESET_DIVISOR;
    end
    else if (wr && at(paddr, `OFS_RECEIVE_STATUS))
    begin
      port_enable <= pwdata[`BIT_PORT_ENABLE];
      nine_bit_receive <= pwdata[`BIT_NINE_RX];
      single_receive_enable <= pwdata[`BIT_SINGLE_RX];
      continuous_receive_enable <= pwdata[`BIT_CONT_RX];
    end
    else
    begin
      if (done && master)
        single_receive_enable <= 1'b0;
      if (wr && at(paddr, `OFS_BAUD_CONFIG))
        wide_baud_counter <= pwdata[`BIT_WIDE_BAUD];
      if (wr && at(paddr, `OFS_DIVISOR_LOW))
        div_lo <= pwdata[7:0];
      if (wr && at(paddr, `OFS_DIVISOR_HIGH))
        div_hi <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {clock_source_select, nine_bit_transmit, transmit_enable} <= 3'b000;
      {sync_mode, high_speed_baud, transmit_ninth_bit} <= 3'b000;
      {receive_irq_enable, transmit_irq_enable} <= 2'b00;
      {peripheral_irq_enable, global_irq_enable} <= 2'b00;
    end
    else
    begin
      if (wr && at(paddr, `OFS_TRANSMIT_STATUS))
      begin
        clock_source_select <= pwdata[`BIT_CLOCK_SOURCE];
        nine_bit_transmit <= pwdata[`BIT_NINE_TX];
        transmit_enable <= pwdata[`BIT_TX_ENABLE];
        sync_mode <= pwdata[`BIT_SYNC_MODE];
        high_speed_baud <= pwdata[`BIT_HIGH_SPEED];
        transmit_ninth_bit <= pwdata[`BIT_TX_NINTH];
      end
      if (wr && at(paddr, `OFS_IRQ_CONTROL))
      begin
        receive_irq_enable <= pwdata[`BIT_RX_IRQ_EN];
        transmit_irq_enable <= pwdata[`BIT_TX_IRQ_EN];
        peripheral_irq_enable <= pwdata[`BIT_PERIPH_IRQ_EN];
        global_irq_enable <= pwdata[`BIT_GLOBAL_IRQ_EN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags, wake and interrupt
  logic receive_complete_flag, transmit_empty_flag, cause;

  assign receive_complete_flag = count != 2'h0;
  assign transmit_empty_flag = transmit_enable && active && !buf_full;
  assign cause = peripheral_irq_enable
    && ((receive_complete_flag && receive_irq_enable)
    || (transmit_empty_flag && transmit_irq_enable));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_request <= 1'b0;
      irq_request <= 1'b0;
    end
    else
    begin
      wake_request <= cause;
      irq_request <= cause && global_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    hit = 1'b1;
    unique case (paddr)
      `OFS_BAUD_CONFIG:
        next_prdata[`BIT_WIDE_BAUD] = wide_baud_counter;
      `OFS_RECEIVE_DATA:
        next_prdata[7:0] = queue[rd_ptr][7:0];
      `OFS_RECEIVE_STATUS:
        next_prdata[7:0] = {port_enable, nine_bit_receive, single_receive_enable,
          continuous_receive_enable, 2'b00, overrun_error_flag,
          queue[rd_ptr][8]};
      `OFS_DIVISOR_LOW:
        next_prdata[7:0] = div_lo;
      `OFS_DIVISOR_HIGH:
        next_prdata[7:0] = div_hi;
      `OFS_TRANSMIT_STATUS:
        next_prdata[7:0] = {clock_source_select, nine_bit_transmit, transmit_enable,
          sync_mode, 1'b0, high_speed_baud, !tsr_full, transmit_ninth_bit};
      `OFS_TRANSMIT_DATA:
        next_prdata = 32'h0000_0000;
      `OFS_IRQ_CONTROL:
        next_prdata[5:0] = {transmit_empty_flag, receive_complete_flag,
          global_irq_enable, peripheral_irq_enable, transmit_irq_enable,
          receive_irq_enable};
      default:
        hit = 1'b0;
    endcase
  end
endmodule

// >>> tb/sync_serial_monitor.sv
// port-level assertion checker for the synchronous serial port
module sync_serial_monitor (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [7:0] paddr, // apb
  input wire logic [31:0] pwdata, // apb
  input wire logic [31:0] prdata, // apb
  input wire logic pready, // apb
  input wire logic pslverr, // apb
  input wire logic cpu_sleep, // sleep
  input wire logic ck_in, // clock pin
  input wire logic ck_out, // clock drive
  input wire logic ck_oe, // clock enable
  input wire logic dt_in, // data pin
  input wire logic dt_out, // data drive
  input wire logic dt_oe, // data enable
  input wire logic wake_request, // wake
  input wire logic irq_request // interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  read_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  ck_drive_a: assert property (!ck_oe |-> !ck_out)
    else $error("clock driven outside master mode");
  irq_wake_a: assert property (irq_request |-> wake_request)
    else $error("interrupt without wake");
  reset_quiet_a: assert property ($rose(presetn) |-> !ck_oe && !dt_oe && !irq_request)
    else $error("port active straight after reset");
  // slave data may only move shortly after a rising pin clock
  slave_lead_a: assert property (!ck_oe && dt_oe && $past(dt_oe) && $changed(dt_out)
    |-> $past(ck_in, 3))
    else $error("slave data changed off the leading edge");
  ////////////////////////////////////////////////////////////////
  cover property ($rose(ck_out));
  cover property ($rose(dt_oe) && !ck_oe);
  cover property ($rose(irq_request));
endmodule

bind sync_serial_port sync_serial_monitor u_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_sleep(cpu_sleep),
  .ck_in(ck_in), .ck_out(ck_out), .ck_oe(ck_oe), .dt_in(dt_in), .dt_out(dt_out),
  .dt_oe(dt_oe), .wake_request(wake_request), .irq_request(irq_request));

// >>> tb/sync_serial_peer.sv
// behavioural far-end peer: clocks the slave, feeds and captures data
module sync_serial_peer (
  input wire logic pclk, // pacing clock
  input wire logic ck_out, // device clock
  input wire logic ck_oe, // device clock enable
  input wire logic dt_line, // resolved data wire
  output logic ck_drv, // peer clock, idle low
  output logic dt_drv // peer data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] words [4];
  logic dt_reg, idle_pat, driving;
  int nbits, idx, bitn;
  initial
  begin
    ck_drv = 1'b0;
    dt_reg = 1'b0;
    idle_pat = 1'b0;
    driving = 1'b0;
    nbits = 8;
  end
  // a released line toggles so a stale level never reads as data
  always @(posedge pclk) idle_pat <= ~idle_pat;
  assign dt_drv = driving ? dt_reg : idle_pat;
  task automatic lead();
    dt_reg <= words[idx][bitn];
    bitn = (bitn + 1) % nbits;
    if (bitn == 0)
      idx = (idx + 1) % 4;
  endtask
  always @(posedge ck_out) if (ck_oe) lead();
  task automatic load(input logic [35:0] ws, input int n);
    for (int i = 0; i < 4; i++)
      words[i] = ws[9*i +: 9];
    nbits = n;
    idx = 0;
    bitn = 0;
    driving = 1'b1;
  endtask
  task automatic quiet();
    driving = 1'b0;
  endtask
  // pin clock only runs inside a transfer, halves of 8 pclk
  task automatic xfer(input int n, output logic [8:0] got);
    got = 9'h000;
    for (int i = 0; i < n; i++)
    begin
      repeat (8) @(posedge pclk);
      ck_drv <= 1'b1;
      lead();
      repeat (8) @(posedge pclk);
      ck_drv <= 1'b0;
      got[i] = dt_line;
    end
    repeat (8) @(posedge pclk);
  endtask
endmodule

// >>> tb/test_sync_serial_port.sv
// self-checking bench for the synchronous serial port
`include "sync_serial_cfg.svh"
module test_sync_serial_port;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] mask; logic [31:0] val; logic err;} note_t;
  logic pclk, presetn, psel, penable, pwrite, cpu_sleep, pready, pslverr;
  logic ck_out, ck_oe, dt_out, dt_oe, wake_request, irq_request;
  logic ck_drv, dt_drv, ck_line, dt_line;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [8:0] got;
  logic [7:0] b [4];
  note_t notes [$];
  note_t n;
  int errors, checks;
  assign ck_line = ck_oe ? ck_out : ck_drv;
  assign dt_line = dt_oe ? dt_out : dt_drv;
  sync_serial_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_sleep(cpu_sleep), .ck_in(ck_line), .ck_out(ck_out),
    .ck_oe(ck_oe), .dt_in(dt_line), .dt_out(dt_out), .dt_oe(dt_oe),
    .wake_request(wake_request), .irq_request(irq_request));
  sync_serial_peer u_peer (.pclk(pclk), .ck_out(ck_out), .ck_oe(ck_oe), .dt_line(dt_line),
    .ck_drv(ck_drv), .dt_drv(dt_drv));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] m, input logic [31:0] e, input logic er);
    int k;
    notes.push_back('{m, e, er});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20)
    begin
      @(posedge pclk);
      k++;
    end
    if (k == 20)
      errors++;
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0, m, e, 1'b0);
  endtask
  // watcher: each completed access is matched with the oldest note
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && notes.size() > 0)
    begin
      n = notes.pop_front();
      check(prdata & n.mask, n.val);
      check({31'h0, pslverr}, {31'h0, n.err});
    end
  end
  initial
  begin
    #300us;
    errors++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    int k;
    void'($urandom(15354));
    {psel, penable, pwrite, presetn, cpu_sleep} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    for (int i = 0; i < 4; i++)
      b[i] = 8'($urandom());
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFS_RECEIVE_STATUS, 32'hFF, 32'h0);
    rd(`OFS_DIVISOR_LOW, 32'hFF, 32'h0);
    apb(1'b0, 8'h20, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1);
    // master, single character, eight bits
    u_peer.load({1'b0, b[3], 1'b0, b[2], 1'b0, b[1], 1'b0, b[0]}, 8);
    wr(`OFS_DIVISOR_LOW, 32'h2);
    wr(`OFS_IRQ_CONTROL, 32'hF);
    wr(`OFS_TRANSMIT_STATUS, 32'h94);
    wr(`OFS_RECEIVE_STATUS, 32'h80);
    wr(`OFS_RECEIVE_STATUS, 32'hA0);
    // divisor 2 at high speed gives a three-cycle high half period
    k = 0;
    while (ck_out !== 1'b1 && k < 2000)
    begin
      @(posedge pclk);
      k++;
    end
    k = 0;
    while (ck_out === 1'b1 && k < 2000)
    begin
      @(posedge pclk);
      k++;
    end
    check(k, 32'h3);
    k = 0;
    while (irq_request !== 1'b1 && k < 2000)
    begin
      @(posedge pclk);
      k++;
    end
    if (k == 2000)
      errors++;
    rd(`OFS_IRQ_CONTROL, 32'h10, 32'h10);
    rd(`OFS_RECEIVE_STATUS, 32'hFF, 32'h80);
    rd(`OFS_RECEIVE_DATA, 32'hFF, {24'h0, b[0]});
    // master, continuous nine-bit until the queue overruns
    u_peer.load({1'b1, b[3], 1'b0, b[2], 1'b1, b[1], 1'b0, b[0]}, 9);
    wr(`OFS_RECEIVE_STATUS, 32'hD0);
    k = 0;
    rdata = 32'h0;
    while (rdata[1] !== 1'b1 && k < 200)
    begin
      rd(`OFS_RECEIVE_STATUS, 32'h0, 32'h0);
      k++;
    end
    if (k == 200)
      errors++;
    rd(`OFS_RECEIVE_STATUS, 32'hFF, 32'hD2);
    wr(`OFS_RECEIVE_STATUS, 32'hC0);
    rd(`OFS_RECEIVE_STATUS, 32'hFF, 32'hC0);
    rd(`OFS_RECEIVE_DATA, 32'hFF, {24'h0, b[0]});
    rd(`OFS_RECEIVE_STATUS, 32'hFF, 32'hC1);
    rd(`OFS_RECEIVE_DATA, 32'hFF, {24'h0, b[1]});
    rd(`OFS_IRQ_CONTROL, 32'h10, 32'h0);
    // slave nine-bit transmit of two words while asleep
    u_peer.quiet();
    wr(`OFS_RECEIVE_STATUS, 32'h80);
    wr(`OFS_TRANSMIT_STATUS, 32'h71);
    wr(`OFS_TRANSMIT_DATA, {24'h0, b[2]});
    wr(`OFS_TRANSMIT_DATA, {24'h0, b[3]});
    cpu_sleep <= 1'b1;
    rd(`OFS_IRQ_CONTROL, 32'h20, 32'h0);
    u_peer.xfer(9, got);
    check({23'h0, got}, {24'h1, b[2]});
    check({30'h0, wake_request, irq_request}, 32'h3);
    rd(`OFS_IRQ_CONTROL, 32'h20, 32'h20);
    u_peer.xfer(9, got);
    check({23'h0, got}, {24'h1, b[3]});
    // slave receive with only the single enable: both characters land
    wr(`OFS_IRQ_CONTROL, 32'h5);
    wr(`OFS_TRANSMIT_STATUS, 32'h10);
    u_peer.load({1'b0, b[0], 1'b0, b[3], 1'b0, b[2], 1'b0, b[1]}, 8);
    wr(`OFS_RECEIVE_STATUS, 32'hA0);
    u_peer.xfer(8, got);
    u_peer.xfer(8, got);
    check({30'h0, wake_request, irq_request}, 32'h2);
    rd(`OFS_RECEIVE_DATA, 32'hFF, {24'h0, b[1]});
    rd(`OFS_RECEIVE_DATA, 32'hFF, {24'h0, b[2]});
    wr(`OFS_RECEIVE_STATUS, 32'h0);
    rd(`OFS_RECEIVE_STATUS, 32'hFF, 32'h0);
    repeat (4) @(posedge pclk);
    finish_test();
  end
endmodule
